// >>> src/pvt_defs.svh
`ifndef PVT_DEFS_SVH
`define PVT_DEFS_SVH

// ============================================================
// frame geometry
`define PVT_V_ACTIVE_LINES 12'd1920
`define PVT_V_CYCLE 12'd1930
`define PVT_V_DATA_START_MIN 12'd4
`define PVT_H_ACTIVE_PIXELS 11'd1080

// ============================================================
// byte codes carried on the lanes
`define PVT_TOK_VSYNC 8'h01
`define PVT_TOK_HSYNC 8'h21
`define PVT_TOK_PIXELS 8'h3e
`define PVT_TOK_DUTY 8'h51
`define PVT_TOK_STATUS 8'h0a

// ============================================================
// timing
`define PVT_CLK_MHZ 100
`define PVT_TOUCH_SYNC_NS 70
`define PVT_TOUCH_SYNC_CYC ((`PVT_TOUCH_SYNC_NS * `PVT_CLK_MHZ) / 1000)
`define PVT_IDLE_NS 320
`define PVT_IDLE_CYC ((`PVT_IDLE_NS * `PVT_CLK_MHZ) / 1000)
`define PVT_ANSWER_NS 160
`define PVT_ANSWER_CYC ((`PVT_ANSWER_NS * `PVT_CLK_MHZ) / 1000)

// ============================================================
// reset values
`define PVT_DUTY_RESET 8'hff

`endif

// >>> src/pvt_fifo.sv
`timescale 1ns/1ns
module pvt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } pvt_fifo_st_t;

  pvt_fifo_st_t s_q, s_d;
  logic full, empty;

  assign empty = (s_q.wr_ptr == s_q.rd_ptr);
  assign full = (s_q.wr_ptr[AW] != s_q.rd_ptr[AW]) &&
                (s_q.wr_ptr[AW-1:0] == s_q.rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s_q.mem[s_q.rd_ptr[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (in_valid && !full) begin
      s_d.mem[s_q.wr_ptr[AW-1:0]] = in_data;
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (out_ready && !empty) begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// >>> src/pvt_frame_rx.sv
`timescale 1ns/1ns
`include "pvt_defs.svh"
// Operation
// - The module drives a tearing-effect output so the host can align frame writes.
// - The module drives a horizontal-scan sync output for an attached touch controller.
// - Data lane zero is two-way on both its lines so the module can answer the host.
// - The module drives a PWM line for its backlight LED driver.
// - Link inputs run host to module and lane zero outputs module to host; the pixel pins face the panel driver.
module pvt_frame_rx
  import pvt_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int V_ACTIVE = 1920,
  parameter int H_ACTIVE = 1080
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link pins from host
  input wire logic link_clk_pin,
  input wire logic bidir_lane_pos_in,
  input wire logic bidir_lane_neg_in,
  input wire logic [2:0] lane_in,
  // lane zero drive back to host
  output logic bidir_lane_pos_out,
  output logic bidir_lane_pos_oe,
  output logic bidir_lane_neg_out,
  output logic bidir_lane_neg_oe,
  // pixels towards the panel driver
  output logic [7:0] pix_data,
  output logic pix_valid,
  input wire logic pix_ready,
  // module outputs
  output logic tearing_effect_out,
  output logic touch_line_sync_out,
  output logic backlight_pwm_line,
  // status
  output logic overflow,
  output logic frame_err,
  output logic line_err
);
  typedef struct packed {
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_s3;
    logic [3:0] dat_s1;
    logic [3:0] dat_s2;
    logic phase;
    logic [3:0] nib_lo;
    pvt_state_t st;
    logic [5:0] idle_cnt;
    logic [10:0] pix_cnt;
    logic [11:0] line_cnt;
    logic [11:0] blank_cnt;
    logic seen_vsync;
    logic te;
    logic [3:0] hs_cnt;
    logic [7:0] pwm_cnt;
    logic [7:0] duty;
    logic pwm;
    logic hold_valid;
    logic [7:0] hold_byte;
    logic ovf;
    logic ferr;
    logic lerr;
    logic ans_req;
    logic [4:0] ans_cnt;
    logic ans_bit;
  } pvt_rx_st_t;

  pvt_rx_st_t s_q, s_d;
  logic fifo_in_ready;
  logic lclk_rise;
  logic [7:0] rx_byte;
  logic byte_done;

  // ============================================================
  // link sampling
  assign lclk_rise = s_q.lclk_s2 && !s_q.lclk_s3;
  assign rx_byte = {s_q.dat_s2, s_q.nib_lo};
  assign byte_done = lclk_rise && s_q.phase;

  function automatic logic [11:0] inc12(input logic [11:0] v);
    return v + 12'd1;
  endfunction

  // ============================================================
  // pixel buffer
  pvt_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(s_q.hold_valid),
    .in_ready(fifo_in_ready),
    .in_data(s_q.hold_byte),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_data)
  );

  // ============================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.lclk_s1 = link_clk_pin;
    s_d.lclk_s2 = s_q.lclk_s1;
    s_d.lclk_s3 = s_q.lclk_s2;
    s_d.dat_s1 = {lane_in, bidir_lane_pos_in};
    s_d.dat_s2 = s_q.dat_s1;

    // buffer drain; a new byte may refill the holding slot below
    if (s_q.hold_valid && fifo_in_ready) begin
      s_d.hold_valid = 1'b0;
    end

    // touch sync pulse
    if (s_q.hs_cnt != 4'h0) begin
      s_d.hs_cnt = s_q.hs_cnt - 4'h1;
    end

    // backlight pwm
    s_d.pwm_cnt = s_q.pwm_cnt + 8'h01;
    s_d.pwm = (s_q.duty == 8'hff) || (s_q.pwm_cnt < s_q.duty);

    // idle detection ends a burst
    if (lclk_rise) begin
      s_d.idle_cnt = '0;
      s_d.phase = !s_q.phase;
      s_d.nib_lo = s_q.dat_s2;
    end else if (s_q.idle_cnt != 6'(`PVT_IDLE_CYC)) begin
      s_d.idle_cnt = s_q.idle_cnt + 6'h01;
    end

    unique case (s_q.st)
      PVT_ST_IDLE: begin
        s_d.phase = lclk_rise;
        if (lclk_rise) begin
          s_d.st = PVT_ST_TYPE;
        end
      end
      PVT_ST_TYPE: begin
        if (byte_done) begin
          s_d.st = PVT_ST_SKIP;
          if (rx_byte == `PVT_TOK_VSYNC) begin
            if (s_q.seen_vsync && s_q.line_cnt != 12'(V_ACTIVE)) begin
              s_d.ferr = 1'b1;
            end
            s_d.seen_vsync = 1'b1;
            s_d.line_cnt = '0;
            s_d.blank_cnt = '0;
            s_d.te = 1'b1;
          end else if (rx_byte == `PVT_TOK_HSYNC) begin
            s_d.hs_cnt = 4'(`PVT_TOUCH_SYNC_CYC);
            if (s_q.line_cnt == '0) begin
              s_d.blank_cnt = inc12(s_q.blank_cnt);
            end
          end else if (rx_byte == `PVT_TOK_PIXELS) begin
            s_d.st = PVT_ST_PIX;
            s_d.pix_cnt = '0;
            if (s_q.line_cnt == '0 && s_q.blank_cnt < `PVT_V_DATA_START_MIN) begin
              s_d.ferr = 1'b1;
            end
          end else if (rx_byte == `PVT_TOK_DUTY) begin
            s_d.st = PVT_ST_DUTY;
          end else if (rx_byte == `PVT_TOK_STATUS) begin
            s_d.ans_req = 1'b1;
          end
        end
      end
      PVT_ST_PIX: begin
        if (byte_done) begin
          s_d.te = 1'b0;
          if (s_q.hold_valid && !fifo_in_ready) begin
            s_d.ovf = 1'b1;
          end else begin
            s_d.hold_valid = 1'b1;
            s_d.hold_byte = rx_byte;
          end
          s_d.pix_cnt = s_q.pix_cnt + 11'h001;
          if (s_q.pix_cnt == 11'(H_ACTIVE - 1)) begin
            s_d.line_cnt = inc12(s_q.line_cnt);
            s_d.st = PVT_ST_SKIP;
          end
        end
      end
      PVT_ST_DUTY: begin
        if (byte_done) begin
          s_d.duty = rx_byte;
          s_d.st = PVT_ST_SKIP;
        end
      end
      PVT_ST_SKIP: begin
      end
      PVT_ST_ANS: begin
        s_d.phase = 1'b0;
        s_d.ans_req = 1'b0;
        s_d.ans_cnt = s_q.ans_cnt - 5'h01;
        if (s_q.ans_cnt == 5'h01) begin
          s_d.st = PVT_ST_IDLE;
        end
      end
      default: begin
        s_d.st = PVT_ST_IDLE;
      end
    endcase

    // end of burst: short line check, then any pending answer
    if (s_q.st != PVT_ST_IDLE && s_q.st != PVT_ST_ANS && !lclk_rise &&
        s_q.idle_cnt == 6'(`PVT_IDLE_CYC - 1)) begin
      s_d.phase = 1'b0;
      if (s_q.st == PVT_ST_PIX) begin
        s_d.lerr = 1'b1;
      end
      if (s_d.ans_req) begin
        s_d.st = PVT_ST_ANS;
        s_d.ans_cnt = 5'(`PVT_ANSWER_CYC);
        s_d.ans_bit = s_d.ovf | s_d.ferr | s_d.lerr;
      end else begin
        s_d.st = PVT_ST_IDLE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= PVT_ST_IDLE;
      s_q.duty <= `PVT_DUTY_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs
  assign bidir_lane_pos_oe = (s_q.st == PVT_ST_ANS);
  assign bidir_lane_neg_oe = (s_q.st == PVT_ST_ANS);
  assign bidir_lane_pos_out = s_q.ans_bit;
  assign bidir_lane_neg_out = !s_q.ans_bit;
  assign tearing_effect_out = s_q.te;
  assign touch_line_sync_out = (s_q.hs_cnt != 4'h0);
  assign backlight_pwm_line = s_q.pwm;
  assign overflow = s_q.ovf;
  assign frame_err = s_q.ferr;
  assign line_err = s_q.lerr;
endmodule

// >>> src/pvt_pkg.sv
package pvt_pkg;

  typedef enum logic [2:0] {
    PVT_ST_IDLE  = 3'b000,
    PVT_ST_TYPE  = 3'b001,
    PVT_ST_PIX   = 3'b010,
    PVT_ST_DUTY  = 3'b011,
    PVT_ST_SKIP  = 3'b100,
    PVT_ST_ANS   = 3'b101
  } pvt_state_t;

endpackage

// >>> testbench/pvt_frame_rx_bench.sv
`timescale 1ns/1ns
`include "pvt_defs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module pvt_frame_rx_bench
  import pvt_pkg::*;
;
  logic clock = 0, rst = 1, pix_ready = 0, rmode = 0;
  logic hp, hn, pos_out, pos_oe, neg_out, neg_oe, lc, te, ts, pwm, ovf, ferr, lerr, pv;
  logic [2:0] ln;
  logic [7:0] pd;
  logic [7:0] exp_q[$];
  int mismatches = 0, checks = 0, keep = 99;
  int ts_cyc = 0, hs_sent = 0;
  initial forever #5 clock = ~clock;
  always @(posedge clock) #1 pix_ready = rmode && ($urandom % 2);
  pvt_frame_rx #(.V_ACTIVE(2), .H_ACTIVE(8)) u_pvt_frame_rx (.clock, .rst,
    .link_clk_pin(lc), .bidir_lane_pos_in(pos_oe ? pos_out : hp),
    .bidir_lane_neg_in(neg_oe ? neg_out : hn), .lane_in(ln), .bidir_lane_pos_out(pos_out),
    .bidir_lane_pos_oe(pos_oe), .bidir_lane_neg_out(neg_out), .bidir_lane_neg_oe(neg_oe),
    .pix_data(pd), .pix_valid(pv), .pix_ready, .tearing_effect_out(te),
    .touch_line_sync_out(ts), .backlight_pwm_line(pwm), .overflow(ovf), .frame_err(ferr),
    .line_err(lerr));
  pvt_host_model u_pvt_host_model (.link_clk_pin(lc), .lane_pos(hp), .lane_neg(hn),
    .lanes(ln));
  // ============================================================
  // output watcher
  always @(negedge clock) if (ts === 1'b1) ts_cyc++;
  always @(negedge clock) if (pv === 1'b1 && pix_ready === 1'b1) begin : watch
    logic [7:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
    `CHK("pix", e, pd)
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hsync;
    hs_sent++;
    u_pvt_host_model.send('{8'h21});
  endtask
  task automatic line(input int n);
    logic [7:0] b[$];
    b = {8'h3e};
    hsync();
    for (int i = 0; i < n; i++) begin
      b.push_back(8'($urandom));
      if (i < 8 && keep > 0) begin
        exp_q.push_back(b[i + 1]);
        keep--;
      end
    end
    u_pvt_host_model.send(b);
  endtask
  task automatic vstart;
    u_pvt_host_model.send('{8'h01});
    repeat (4) hsync();
  endtask
  task automatic status(input logic e);
    int i;
    fork
      u_pvt_host_model.send('{8'h0a});
      begin
        for (i = 0; i < 200 && pos_oe !== 1'b1; i++) @(posedge clock);
        if (i == 200) begin
          mismatches++;
          give_verdict();
        end
        #2 `CHK("lane0", e, pos_out)
      end
    join
  endtask
  // ============================================================
  // main sequence
  initial begin
    int d, i, hi;
    void'($urandom(55));
    repeat (20) @(posedge clock);
    #1 rst = 0;
    repeat (3) @(posedge clock);
    `CHK("pwm", 1'b1, pwm)
    `CHK("te", 1'b0, te)
    rmode = 1;
    d = $urandom % 255;
    u_pvt_host_model.send('{8'h51, 8'(d)});
    repeat (600) @(posedge clock);
    hi = 0;
    repeat (256) begin
      @(posedge clock);
      hi += pwm;
    end
    `CHK("duty", d, hi)
    vstart();
    `CHK("te", 1'b1, te)
    line(8);
    `CHK("te", 1'b0, te)
    line(10);
    u_pvt_host_model.send('{8'h01});
    `CHK("ferr", 1'b0, ferr)
    status(1'b0);
    rmode = 0;
    keep = 17;
    repeat (4) hsync();
    repeat (3) line(8);
    `CHK("ovf", 1'b1, ovf)
    rmode = 1;
    for (i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clock);
    `CHK("drain", 0, exp_q.size())
    u_pvt_host_model.send('{8'h01});
    `CHK("ferr", 1'b1, ferr)
    repeat (4) hsync();
    keep = 3;
    line(3);
    `CHK("lerr", 1'b1, lerr)
    status(1'b1);
    repeat (100) @(posedge clock);
    // mid-run reset, then a frame with too few blank lines
    #1 rst = 1;
    repeat (2) @(posedge clock);
    #1 rst = 0;
    repeat (3) @(posedge clock);
    `CHK("pwm", 1'b1, pwm)
    `CHK("ovf", 1'b0, ovf)
    `CHK("ferr", 1'b0, ferr)
    `CHK("lerr", 1'b0, lerr)
    u_pvt_host_model.send('{8'h01});
    repeat (2) hsync();
    keep = 8;
    line(8);
    `CHK("ferr", 1'b1, ferr)
    repeat (100) @(posedge clock);
    `CHK("touch", `PVT_TOUCH_SYNC_CYC * hs_sent, ts_cyc)
    give_verdict();
  end
  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end
endmodule

// >>> testbench/pvt_frame_rx_sva.sv
`timescale 1ns/1ns
// ============================================================
// port checks
module pvt_frame_rx_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched outputs
  input wire logic [7:0] pix_data,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic tearing_effect_out,
  input wire logic touch_line_sync_out,
  input wire logic bidir_lane_pos_out,
  input wire logic bidir_lane_pos_oe,
  input wire logic bidir_lane_neg_out,
  input wire logic bidir_lane_neg_oe,
  input wire logic overflow,
  input wire logic frame_err,
  input wire logic line_err
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  touch_width_a: assert property (
    $rose(touch_line_sync_out) |-> touch_line_sync_out[*7] ##1 !touch_line_sync_out)
    else $error("touch sync width wrong");
  lane_hold_a: assert property (
    $rose(bidir_lane_pos_oe) |-> bidir_lane_pos_oe[*8] ##1 bidir_lane_pos_oe[*8]
    ##1 !bidir_lane_pos_oe) else $error("lane drive length wrong");
  neg_enable_a: assert property (
    bidir_lane_neg_oe == bidir_lane_pos_oe) else $error("lane enables differ");
  neg_level_a: assert property (
    bidir_lane_pos_oe |-> bidir_lane_neg_out != bidir_lane_pos_out)
    else $error("lane lines not complementary");
  status_bit_a: assert property (
    bidir_lane_pos_oe |-> bidir_lane_pos_out == (overflow | frame_err | line_err))
    else $error("status bit wrong");
  pix_hold_a: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data)) else $error("pixel dropped");
  te_clear_a: assert property (
    $rose(tearing_effect_out) |-> !pix_valid) else $error("te with pixels pending");
  ovf_sticky_a: assert property (
    overflow |=> overflow) else $error("overflow cleared");
  err_sticky_a: assert property (
    frame_err || line_err |=> frame_err || line_err) else $error("error flag cleared");
endmodule
bind pvt_frame_rx pvt_frame_rx_sva u_pvt_frame_rx_sva (.clock, .rst, .pix_data, .pix_valid,
  .pix_ready, .tearing_effect_out, .touch_line_sync_out, .bidir_lane_pos_out,
  .bidir_lane_pos_oe, .bidir_lane_neg_out, .bidir_lane_neg_oe, .overflow, .frame_err,
  .line_err);

// >>> testbench/pvt_host_model.sv
`timescale 1ns/1ns
// ============================================================
// host end of the link
module pvt_host_model (
  // link pins towards the receiver
  output logic link_clk_pin,
  output logic lane_pos,
  output logic lane_neg,
  output logic [2:0] lanes
);
  initial begin
    link_clk_pin = 0;
    {lanes, lane_pos} = 4'h5;
    lane_neg = 0;
  end
  // clock stands low between bursts
  task automatic send(input logic [7:0] b[$]);
    #3;
    foreach (b[i]) for (int n = 0; n < 2; n++) begin
      {lanes, lane_pos} = n ? b[i][7:4] : b[i][3:0];
      lane_neg = !lane_pos;
      #40 link_clk_pin = 1;
      #40 link_clk_pin = 0;
    end
    {lanes, lane_pos} = ~{lanes, lane_pos};
    lane_neg = !lane_pos;
    #600;
  endtask
endmodule
